// [rtl/pmicsl_slave.sv]
// Two-wire serial slave port with buck control register and status read
`timescale 1ns/1ps
module pmicsl_slave (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     resetn_i,
  // Serial bus pins
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  // Supply and power state
  input  wire logic                     interface_supply_uvlo_i,
  input  wire logic                     power_down_state_i,
  // Status inputs
  input  wire pmicsl_pkg::pmicsl_status_type status_i,
  // Regulator controls
  output logic                          buck1_burst_select_o,
  output logic                          buck2_burst_select_o,
  output logic                          buck3_burst_select_o,
  output logic [1:0]                    switch_slew_sel_o
);
  import pmicsl_pkg::*;

  // ************************************************************
  // Input conditioning
  // ************************************************************
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
  } pmicsl_state_type;

  pmicsl_bus_type   bus;
  pmicsl_bus_type   bus_q;
  pmicsl_ctrl_type  ctrl;
  logic [1:0]       pin_raw;
  logic [1:0]       pin_filt;
  pmicsl_status_type status_s1;
  pmicsl_status_type status_s2;
  logic             uvlo_s1;
  logic             uvlo_s2;
  logic             pdn_s1;
  logic             pdn_s2;
  logic             port_clear;

  // Bit 1 carries the clock line, bit 0 the data line
  assign pin_raw = {scl_i, sda_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      pmicsl_filter u_filt (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (pin_raw[gi]),
        .level_o   (pin_filt[gi])
      );
    end
  endgenerate

  assign bus = pin_filt;

  // Supply, power state and status arrive from other domains
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uvlo_s1 <= 1'b0;
      uvlo_s2 <= 1'b0;
      pdn_s1  <= 1'b0;
      pdn_s2  <= 1'b0;
      bus_q   <= '1;
      status_s1 <= '0;
      status_s2 <= '0;
    end else begin
      uvlo_s1 <= interface_supply_uvlo_i;
      uvlo_s2 <= uvlo_s1;
      pdn_s1  <= power_down_state_i;
      pdn_s2  <= pdn_s1;
      bus_q   <= bus;
      status_s1 <= status_i;
      status_s2 <= status_s1;
    end
  end

  assign port_clear = uvlo_s2;

  // ************************************************************
  // Bus event detection
  // ************************************************************
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  assign start_det = bus.scl && bus_q.scl && bus_q.sda && !bus.sda;
  assign stop_det  = bus.scl && bus_q.scl && !bus_q.sda && bus.sda;
  assign scl_rise  = bus.scl && !bus_q.scl;
  assign scl_fall  = !bus.scl && bus_q.scl;

  // ************************************************************
  // Protocol state machine
  // ************************************************************
  pmicsl_state_type state;
  pmicsl_state_type next_state;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic [3:0]       bitcnt;
  logic [3:0]       next_bitcnt;
  logic             sub_ok;
  logic             next_sub_ok;
  logic             drive_low;
  logic             next_drive_low;
  logic             hold_load;
  logic             commit;
  logic             shreg_is_read;
  logic             next_is_read;

  function automatic logic addr_match(input logic [7:0] b);
    addr_match = (b[7:1] == DEV_ADDR);
  endfunction : addr_match

  always_comb begin
    next_state     = state;
    next_shreg     = shreg;
    next_bitcnt    = bitcnt;
    next_sub_ok    = sub_ok;
    next_drive_low = drive_low;
    hold_load      = 1'b0;
    commit         = 1'b0;
    if (start_det) begin
      next_state     = ST_ADDR;
      next_bitcnt    = 4'h0;
      next_drive_low = 1'b0;
    end else if (stop_det) begin
      next_state     = ST_IDLE;
      next_drive_low = 1'b0;
      commit         = 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_SUB, ST_DATA: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], bus.sda};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'(BYTE_BITS)) begin
            next_bitcnt = 4'h0;
            if (state == ST_ADDR) begin
              if (addr_match(shreg)) begin
                next_drive_low = 1'b1;
                next_state     = ST_ADDR_ACK;
                if (shreg[0]) begin
                  next_shreg = status_s2;
                end
              end else begin
                next_state = ST_IGNORE;
              end
            end else if (state == ST_SUB) begin
              next_sub_ok    = (shreg == SUB_ADDR_CTRL);
              next_drive_low = 1'b1;
              next_state     = ST_SUB_ACK;
            end else begin
              next_drive_low = 1'b1;
              hold_load      = sub_ok;
              next_state     = ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_SUB_ACK, ST_DATA_ACK: begin
          // Release only after the ninth clock falls
          if (scl_fall) begin
            next_drive_low = 1'b0;
            case (state)
              ST_ADDR_ACK: begin
                if (shreg_is_read) begin
                  next_state     = ST_TX;
                  next_drive_low = !shreg[7];
                end else begin
                  next_state = ST_SUB;
                end
              end
              ST_SUB_ACK: next_state = ST_DATA;
              default:    next_state = ST_IGNORE;
            endcase
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 4'h1;
            next_shreg  = {shreg[6:0], 1'b1};
            if (bitcnt == 4'(BYTE_BITS - 1)) begin
              next_drive_low = 1'b0;
              next_state     = ST_TX_ACK;
            end else begin
              next_drive_low = !shreg[6];
            end
          end
        end
        ST_TX_ACK: begin
          // Master answer is not examined
          if (scl_fall) begin
            next_state = ST_IGNORE;
          end
        end
        default: begin
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  // Read direction remembered apart from the shifted status
  always_comb begin
    next_is_read = shreg_is_read;
    if (state == ST_ADDR && scl_fall && bitcnt == 4'(BYTE_BITS)) begin
      next_is_read = shreg[0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state         <= ST_IDLE;
      shreg         <= 8'h00;
      bitcnt        <= 4'h0;
      sub_ok        <= 1'b0;
      drive_low     <= 1'b0;
      shreg_is_read <= 1'b0;
    end else if (port_clear) begin
      state         <= ST_IDLE;
      shreg         <= 8'h00;
      bitcnt        <= 4'h0;
      sub_ok        <= 1'b0;
      drive_low     <= 1'b0;
      shreg_is_read <= 1'b0;
    end else begin
      state         <= next_state;
      shreg         <= next_shreg;
      bitcnt        <= next_bitcnt;
      sub_ok        <= next_sub_ok;
      drive_low     <= next_drive_low;
      shreg_is_read <= next_is_read;
    end
  end

  // Open drain: only low is ever driven
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_low;

  // ************************************************************
  // Control register
  // ************************************************************
  pmicsl_ctrl_reg u_ctrl (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .clear_i     (port_clear || pdn_s2),
    .hold_load_i (hold_load),
    .hold_data_i (shreg),
    .commit_i    (commit),
    .ctrl_o      (ctrl)
  );

  assign buck1_burst_select_o = ctrl.buck1_burst_select;
  assign buck2_burst_select_o = ctrl.buck2_burst_select;
  assign buck3_burst_select_o = ctrl.buck3_burst_select;
  assign switch_slew_sel_o    = ctrl.switch_slew_sel;

  // ************************************************************
  // Checks
  // ************************************************************
  a_ack_held: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || port_clear)
    (state == ST_ADDR_ACK || state == ST_SUB_ACK || state == ST_DATA_ACK)
      && bus.scl && !start_det && !stop_det |-> sda_oe_o)
    else $error("Acknowledge not held during clock high");
  a_no_ack_miss: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    state == ST_IGNORE |-> !sda_oe_o)
    else $error("Data driven while ignoring transfer");
  a_tx_release: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    state == ST_TX_ACK |-> !sda_oe_o)
    else $error("Data not released for master acknowledge");
  a_start_goes: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || port_clear)
    start_det |=> state == ST_ADDR && bitcnt == 4'h0)
    else $error("START not taken");
  a_stop_idle: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || port_clear)
    stop_det && !start_det |=> state == ST_IDLE && !sda_oe_o)
    else $error("STOP not taken");
  a_uvlo_clear: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    port_clear |=> state == ST_IDLE && !sda_oe_o)
    else $error("Port not cleared under undervoltage");
  a_pdn_clear: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    pdn_s2 |=> !buck1_burst_select_o && !buck2_burst_select_o
      && !buck3_burst_select_o && switch_slew_sel_o == SLEW_1NS)
    else $error("Controls not cleared in power-down");
  a_status_load: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i || port_clear)
    state == ST_ADDR && next_state == ST_ADDR_ACK && shreg[0]
      |=> shreg == $past(status_s2))
    else $error("Status not sampled at read acknowledge");
endmodule : pmicsl_slave

// [pkg/pmicsl_pkg.sv]
// Package of constants and types for the serial slave control port
// Notes on behaviour
// - Interface supply undervoltage resets the port and clears all control bits.
// - Clock and data inputs are filtered so short glitches are ignored.
// - Data falling while clock high is START and begins a transfer.
// - Data rising while clock high is STOP and commits new command data.
// - Bytes are eight bits, MSB first, then a ninth acknowledge clock.
// - Write: acknowledge address and both bytes; read: acknowledge address only.
// - Acknowledge holds data low through the whole acknowledge clock high phase.
// - After the status byte data is released; missing master acknowledge is harmless.
// - Respond to address 0001001; byte 0x12 writes, 0x13 reads.
// - A write is address byte, sub-address byte, then one data byte.
// - Data byte for sub-address 0x00 enters the holding latch when its acknowledge is given.
// - Holding data survives repeated STARTs; command latches load only at STOP.
// - After read acknowledge, eight status bits go out; STOP not needed.
// - Control bits clear at power-up, supply undervoltage and power-down state.
// - Bits B2..B4 select burst (1) or pulse-skipping (0) per buck.
// - Bits B6:B5 pick common slew rate 1, 2, 4 or 8 ns.
// - Bits B0, B1 and B7 have no effect.
// - Status byte is sampled at the read address acknowledge.
// - Status: A0 charging, A2:A1 fault code, A3..A7 power-good flags.
package pmicsl_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h09;
  localparam logic [7:0] SUB_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int         BIT_BUCK1_BURST = 2;
  localparam int         BIT_BUCK2_BURST = 3;
  localparam int         BIT_BUCK3_BURST = 4;
  localparam int         BIT_SLEW_LOW    = 5;
  localparam int         BIT_SLEW_HIGH   = 6;
  localparam int         BYTE_BITS       = 8;
  localparam int         SYNC_STAGES     = 2;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         GLITCH_NS       = 50;
  // Level must stand this many samples; shorter spikes are dropped
  localparam int         FILT_CYCLES     =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SLEW_1NS        = 2'h0;
  localparam logic [1:0] SLEW_2NS        = 2'h1;
  localparam logic [1:0] SLEW_4NS        = 2'h2;
  localparam logic [1:0] SLEW_8NS        = 2'h3;

  typedef struct packed {
    logic [2:0] buck_power_good;
    logic [1:0] ldo_power_good;
    logic [1:0] charger_fault;
    logic       charging;
  } pmicsl_status_type;

  typedef struct packed {
    logic [1:0] switch_slew_sel;
    logic       buck3_burst_select;
    logic       buck2_burst_select;
    logic       buck1_burst_select;
  } pmicsl_ctrl_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } pmicsl_bus_type;
endpackage : pmicsl_pkg

// [rtl/pmicsl_filter.sv]
// Two-flop synchroniser followed by a stability glitch filter
`timescale 1ns/1ps
module pmicsl_filter (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // Raw pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);
  import pmicsl_pkg::*;

  logic [SYNC_STAGES-1:0] sync;
  logic [2:0]             cnt;
  logic [2:0]             next_cnt;
  logic                   next_level;

  // Idle bus is high, so reset to high
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync <= '1;
    end else begin
      sync <= {sync[0], pin_i};
    end
  end

  always_comb begin
    next_cnt   = 3'h0;
    next_level = level_o;
    if (sync[1] != level_o) begin
      next_cnt = cnt + 3'h1;
      if (cnt == 3'(FILT_CYCLES - 1)) begin
        next_level = sync[1];
        next_cnt   = 3'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt     <= 3'h0;
      level_o <= 1'b1;
    end else begin
      cnt     <= next_cnt;
      level_o <= next_level;
    end
  end

  a_filter_glitch: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    $changed(level_o) |-> $past(sync[1], 1) == level_o)
    else $error("Filtered level changed without stable input");
endmodule : pmicsl_filter

// [rtl/pmicsl_ctrl_reg.sv]
// Holding latch and command latches of the buck control register
`timescale 1ns/1ps
module pmicsl_ctrl_reg (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  // Clears
  input  wire logic                   clear_i,
  // Load strobes and data
  input  wire logic                   hold_load_i,
  input  wire logic [7:0]             hold_data_i,
  input  wire logic                   commit_i,
  // Command latch outputs
  output pmicsl_pkg::pmicsl_ctrl_type ctrl_o
);
  import pmicsl_pkg::*;

  logic [7:0] hold;
  logic [7:0] cmd;
  logic [7:0] next_hold;
  logic [7:0] next_cmd;

  always_comb begin
    next_hold = hold;
    next_cmd  = cmd;
    if (clear_i) begin
      next_hold = CTRL_RESET;
      next_cmd  = CTRL_RESET;
    end else begin
      if (hold_load_i) begin
        next_hold = hold_data_i;
      end
      if (commit_i) begin
        next_cmd = hold;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold <= CTRL_RESET;
      cmd  <= CTRL_RESET;
    end else begin
      hold <= next_hold;
      cmd  <= next_cmd;
    end
  end

  // Unused bits B0, B1, B7 never reach an output
  assign ctrl_o.buck1_burst_select = cmd[BIT_BUCK1_BURST];
  assign ctrl_o.buck2_burst_select = cmd[BIT_BUCK2_BURST];
  assign ctrl_o.buck3_burst_select = cmd[BIT_BUCK3_BURST];
  assign ctrl_o.switch_slew_sel    =
    {cmd[BIT_SLEW_HIGH], cmd[BIT_SLEW_LOW]};

  a_commit_copy: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    commit_i && !clear_i |=> cmd == $past(hold))
    else $error("Command latch did not take holding data at STOP");
  a_clear_all: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    clear_i |=> cmd == CTRL_RESET && hold == CTRL_RESET)
    else $error("Control bits not cleared");
  a_hold_stable: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
    !hold_load_i && !clear_i |=> hold == $past(hold))
    else $error("Holding latch changed without load");
endmodule : pmicsl_ctrl_reg

// [verification/pmicsl_master.sv]
// Behavioural two-wire bus master driving the serial slave port
`timescale 1ns/1ps
module pmicsl_master #(
  parameter int SCL_NS = 2500
) (
  // Bus lines, data is open drain with pull-up
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  localparam int Q = SCL_NS / 4;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Also a repeated START when entered with the clock low
  task automatic start_cond();
    sda_low_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_low_o = 1'b1;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask : start_cond

  // Clock stands high and data released afterwards
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_low_o = 1'b0;
    #Q;
  endtask : stop_cond

  task automatic send_bit(input logic b);
    sda_low_o = ~b;
    #Q;
    scl_o = 1'b1;
    #(2 * Q);
    scl_o = 1'b0;
    #Q;
  endtask : send_bit

  // Ack must be low at both ends of the high phase
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a1;
    logic a2;
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    sda_low_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #1;
    a1 = sda_i;
    #(2 * Q - 2);
    a2 = sda_i;
    #1;
    scl_o = 1'b0;
    #Q;
    ack = ~a1 & ~a2;
  endtask : wbyte

  task automatic rbyte(output logic [7:0] d, input logic mack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #Q;
      d[i] = sda_i;
      #Q;
      scl_o = 1'b0;
      #Q;
    end
    send_bit(~mack);
  endtask : rbyte

  // Spike shorter than the input filter
  task automatic glitch(input int ns);
    scl_o = 1'b1;
    #ns;
    scl_o = 1'b0;
    // Pad back onto the usual stimulus grid
    #(Q - ns);
  endtask : glitch
endmodule : pmicsl_master

// [verification/tb_top.sv]
// Self-checking bench for the serial slave control port
`timescale 1ns/1ps
module tb_top;
  import pmicsl_pkg::*;
  localparam logic [7:0] WR = {DEV_ADDR, 1'b0};
  localparam logic [7:0] RD = {DEV_ADDR, 1'b1};
  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] data;
    logic [7:0] ctrl;
  } pmicsl_row_type;

  logic              clk_sys, resetn, scl, sda_low, sda_line;
  logic              sda_o, sda_oe, uvlo, power_down_state, b1, b2, b3;
  logic [1:0]        slew;
  logic [7:0]        rd;
  pmicsl_status_type status;
  int                n_mismatch, cmp_count;
  // Expected controls as {000, slew, buck3, buck2, buck1}
  pmicsl_row_type    rows [8] = '{
    '{8'h00, 8'h7c, 8'h1f}, '{8'h00, 8'h00, 8'h00},
    '{8'h00, 8'h24, 8'h09}, '{8'h00, 8'h48, 8'h12},
    '{8'h00, 8'h10, 8'h04}, '{8'h00, 8'h60, 8'h18},
    '{8'h00, 8'h83, 8'h00}, '{8'h01, 8'h7c, 8'h00}};

  assign sda_line = ~sda_low & (sda_oe ? sda_o : 1'b1);

  pmicsl_slave dut (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .interface_supply_uvlo_i(uvlo), .power_down_state_i(power_down_state),
    .status_i(status), .buck1_burst_select_o(b1),
    .buck2_burst_select_o(b2), .buck3_burst_select_o(b3),
    .switch_slew_sel_o(slew));

  pmicsl_master u_master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ***************************************
  // Helpers
  // ***************************************
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wclk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wclk

  task automatic wb(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_master.wbyte(b, ack);
    chk("ack", {7'h0, exp_ack}, {7'h0, ack});
  endtask : wb

  task automatic chk_ctrl(input logic [7:0] e);
    wclk(10);
    chk("ctrl", e, {3'h0, slew, b3, b2, b1});
  endtask : chk_ctrl

  task automatic write_reg(input logic [7:0] sub, input logic [7:0] d);
    u_master.start_cond();
    wb(WR, 1'b1);
    wb(sub, 1'b1);
    wb(d, 1'b1);
    u_master.stop_cond();
  endtask : write_reg

  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    resetn = 1'b0;
    uvlo = 1'b0;
    power_down_state = 1'b0;
    status = '0;
    n_mismatch = 0;
    cmp_count = 0;
    wclk(6);
    resetn = 1'b1;
    chk_ctrl(8'h00);
    chk("oe", 8'h00, {7'h0, sda_oe});
    $display("test reset done");
    foreach (rows[i]) begin
      write_reg(rows[i].sub, rows[i].data);
      chk_ctrl(rows[i].ctrl);
    end
    $display("test register rows done");
    write_reg(8'h00, 8'h7c);
    status = 8'hc6;
    u_master.start_cond();
    wb(RD, 1'b1);
    status = 8'h39;
    u_master.rbyte(rd, 1'b0);
    chk("status", 8'hc6, rd);
    chk("oe", 8'h00, {7'h0, sda_oe});
    write_reg(8'h00, 8'h24);
    chk_ctrl(8'h09);
    $display("test status read done");
    u_master.start_cond();
    wb(WR, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h7c, 1'b1);
    u_master.start_cond();
    wb(8'h40, 1'b0);
    wb(8'h55, 1'b0);
    chk_ctrl(8'h09);
    u_master.stop_cond();
    chk_ctrl(8'h1f);
    u_master.start_cond();
    wb(8'h14, 1'b0);
    wb(8'h00, 1'b0);
    u_master.stop_cond();
    chk_ctrl(8'h1f);
    $display("test repeated start done");
    u_master.start_cond();
    wb(WR, 1'b1);
    u_master.glitch(20);
    wb(8'h00, 1'b1);
    u_master.glitch(20);
    wb(8'h48, 1'b1);
    u_master.stop_cond();
    chk_ctrl(8'h12);
    $display("test glitch done");
    power_down_state = 1'b1;
    chk_ctrl(8'h00);
    power_down_state = 1'b0;
    write_reg(8'h00, 8'h7c);
    chk_ctrl(8'h1f);
    u_master.start_cond();
    wb(WR, 1'b1);
    wb(8'h00, 1'b1);
    uvlo = 1'b1;
    chk_ctrl(8'h00);
    chk("oe", 8'h00, {7'h0, sda_oe});
    uvlo = 1'b0;
    wclk(6);
    wb(8'h7c, 1'b0);
    u_master.stop_cond();
    chk_ctrl(8'h00);
    $display("test clears done");
    end_sim();
  end

  // Run is near 45k cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    $display("Error watchdog expected end seen timeout");
    end_sim();
  end
endmodule : tb_top
